// file: hdl/epp_pkg.sv
// How it works
// - Direction bit 0 counts up clockwise
// - Direction applies only with class function on
// - Controller presets again after direction change
// - Class function gates direction, preset, scaling
// - Preset always shifts words two and three
// - First-word preset control: 0 enables, 1 disables
// - First-word preset control needs class function
// - Scaling 0 hardware, 1 programmed resolution
// - Programmed scaling needs class and scaling on
// - Scaling values bounded by hardware resolution
// - Alarm control 1 adds encoder faults
// - Alarm control honoured only in compatibility mode
// - Compatibility bit 0 enables, 1 disables
// - Compatibility ignores request bit, status reads 0
// - Profile number 31 compatible, 41 otherwise
// - Units per revolution 1..hardware, default hardware
// - Power of two units is only recommended
// - Controller presets again after units change
// - Settings in byte 0 bits 0 to 5
package epp_pkg;
  localparam int PW           = 32;
  localparam int ST_BITS      = 16;
  localparam int MT_BITS      = 14;
  localparam logic [PW-1:0] HW_CPR   = 32'h0001_0000;
  localparam logic [PW-1:0] HW_RANGE = 32'h4000_0000;
  localparam int BIT_DIR      = 0;
  localparam int BIT_CLASS    = 1;
  localparam int BIT_X1PRE    = 2;
  localparam int BIT_SCALE    = 3;
  localparam int BIT_ALARM    = 4;
  localparam int BIT_COMPAT   = 5;
  localparam logic [7:0] CFG_RESET = 8'h22;
  localparam logic [7:0] PROF_COMPAT = 8'h1f;
  localparam logic [7:0] PROF_NEW    = 8'h29;
  localparam logic [7:0] LIFE_DEFAULT = 8'h01;
  localparam int STEP_WAIT    = 3;
endpackage : epp_pkg

// file: hdl/epp_link_if.sv
`timescale 1ns/100ps
interface epp_link_if;
  import epp_pkg::*;
  logic [7:0]    cfg_byte;
  logic [PW-1:0] units_per_rev;
  logic [PW-1:0] total_range;
  logic          cfg_load;
  logic          preset_req;
  logic [PW-1:0] preset_val;
  logic          plc_control_request_bit;
  logic          enc_fault;
  logic [PW-1:0] position_word_one;
  logic [PW-1:0] position_word_two;
  logic [PW-1:0] position_word_three;
  logic          control_requested_status_bit;
  logic          alarm_diag;
  logic          ctrl_valid;
  logic [7:0]    profile_number_param;
  logic [7:0]    life_fail_limit;
  logic          cfg_bad;
  modport device (
    input  cfg_byte, units_per_rev, total_range, cfg_load, preset_req,
    input  preset_val, plc_control_request_bit, enc_fault,
    output position_word_one, position_word_two, position_word_three,
    output control_requested_status_bit, alarm_diag, ctrl_valid,
    output profile_number_param, life_fail_limit, cfg_bad
  );
  modport host (
    output cfg_byte, units_per_rev, total_range, cfg_load, preset_req,
    output preset_val, plc_control_request_bit, enc_fault,
    input  position_word_one, position_word_two, position_word_three,
    input  control_requested_status_bit, alarm_diag, ctrl_valid,
    input  profile_number_param, life_fail_limit, cfg_bad
  );
endinterface : epp_link_if

// file: hdl/epp_device.sv
`timescale 1ns/100ps
module epp_device (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst,
  // Link to controller
  epp_link_if.device           link,
  // Raw sensor side
  input  wire logic [epp_pkg::PW-1:0] raw_pos,
  input  wire logic            raw_fault
);
  import epp_pkg::*;

  logic [7:0]    cfg_q;
  logic [PW-1:0] upr_q;
  logic [PW-1:0] rng_q;
  logic [PW-1:0] off_q;
  logic [PW-1:0] pos1_q, pos2_q, pos3_q;
  logic          req_q, alarm_q, valid_q, bad_q;
  logic [7:0]    prof_q, life_q;
  logic [PW-1:0] raw_s1_q, raw_s2_q;
  logic          flt_s1_q, flt_s2_q;

  logic          class_on, dir_ccw, x1pre_on, scale_on, compat_on;
  logic [PW-1:0] dir_pos, scaled, shifted;
  logic [63:0]   prod;

  // Wrap value into range
  function automatic logic [PW-1:0] wrap(input logic [PW-1:0] v,
                                         input logic [PW-1:0] m);
    wrap = (m == '0) ? v : v % m;
  endfunction : wrap

  // Sensor pins synchroniser
  always_ff @(posedge sys_clk) begin
    raw_s1_q <= raw_pos;
    raw_s2_q <= raw_s1_q;
    flt_s1_q <= raw_fault;
    flt_s2_q <= flt_s1_q;
  end

  // Decoded settings
  assign class_on  = cfg_q[BIT_CLASS];
  assign dir_ccw   = class_on & cfg_q[BIT_DIR];
  assign x1pre_on  = ~class_on | ~cfg_q[BIT_X1PRE];
  assign scale_on  = class_on & cfg_q[BIT_SCALE];
  assign compat_on = ~cfg_q[BIT_COMPAT];

  // Direction, then scale, then wrap
  always_comb begin
    dir_pos = dir_ccw ? wrap(HW_RANGE - raw_s2_q, HW_RANGE)
                      : raw_s2_q;
    prod    = 64'(dir_pos) * 64'(upr_q);
    scaled  = scale_on ? wrap(PW'(prod >> ST_BITS), rng_q)
                       : dir_pos;
    shifted = wrap(scaled + off_q, scale_on ? rng_q : HW_RANGE);
  end

  // Settings record load
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg_q  <= CFG_RESET;
      upr_q  <= HW_CPR;
      rng_q  <= HW_RANGE;
      life_q <= LIFE_DEFAULT;
      bad_q  <= 1'b0;
    end else if (link.cfg_load) begin
      cfg_q  <= {2'b00, link.cfg_byte[5:0]};
      if (link.units_per_rev >= 1 && link.units_per_rev <= HW_CPR &&
          link.total_range >= 2 && link.total_range <= HW_RANGE) begin
        upr_q <= link.units_per_rev;
        rng_q <= link.total_range;
        bad_q <= 1'b0;
      end else begin
        bad_q <= 1'b1;
      end
    end
  end

  // Preset offset
  always_ff @(posedge sys_clk) begin
    if (rst)
      off_q <= '0;
    else if (link.preset_req)
      off_q <= link.preset_val - scaled;
  end

  // Position words
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pos1_q <= '0;
      pos2_q <= '0;
      pos3_q <= '0;
    end else begin
      pos1_q <= x1pre_on ? shifted : scaled;
      pos2_q <= shifted;
      pos3_q <= shifted;
    end
  end

  // Compatibility and alarm behaviour
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      req_q   <= 1'b0;
      valid_q <= 1'b1;
      alarm_q <= 1'b0;
      prof_q  <= PROF_NEW;
    end else begin
      req_q   <= compat_on ? 1'b0 : link.plc_control_request_bit;
      valid_q <= compat_on | link.plc_control_request_bit;
      alarm_q <= (compat_on ? cfg_q[BIT_ALARM] : 1'b1)
                 & (flt_s2_q | link.enc_fault);
      prof_q  <= compat_on ? PROF_COMPAT : PROF_NEW;
    end
  end

  // Outputs
  assign link.position_word_one   = pos1_q;
  assign link.position_word_two   = pos2_q;
  assign link.position_word_three = pos3_q;
  assign link.control_requested_status_bit = req_q;
  assign link.ctrl_valid          = valid_q;
  assign link.alarm_diag          = alarm_q;
  assign link.profile_number_param = prof_q;
  assign link.life_fail_limit     = compat_on ? life_q : LIFE_DEFAULT;
  assign link.cfg_bad             = bad_q;
endmodule : epp_device

// file: hdl/epp_host.sv
`timescale 1ns/100ps
module epp_host (
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            rst,
  // Link to device
  epp_link_if.host             link,
  // User command side
  input  wire logic            usr_load,
  input  wire logic [7:0]      usr_cfg,
  input  wire logic [epp_pkg::PW-1:0] usr_upr,
  input  wire logic [epp_pkg::PW-1:0] usr_rng,
  input  wire logic [epp_pkg::PW-1:0] usr_preset,
  input  wire logic            usr_req,
  output logic                 usr_busy
);
  import epp_pkg::*;
  typedef enum logic [1:0] {S_IDLE, S_LOAD, S_WAIT, S_PRESET} epp_st_t;
  epp_st_t st_q;
  logic [1:0] cnt_q;
  logic [7:0] cfg_q;
  logic [PW-1:0] upr_q, rng_q, pre_q;
  logic req_q;

  // Settings then preset sequence
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q  <= S_IDLE;
      cnt_q <= '0;
      cfg_q <= CFG_RESET;
      upr_q <= HW_CPR;
      rng_q <= HW_RANGE;
      pre_q <= '0;
    end else begin
      case (st_q)
        S_IDLE: if (usr_load) begin
          cfg_q <= {2'b00, usr_cfg[5:0]};
          upr_q <= (usr_upr == '0) ? 32'h1 :
                   (usr_upr > HW_CPR) ? HW_CPR : usr_upr;
          rng_q <= (usr_rng > HW_RANGE) ? HW_RANGE : usr_rng;
          pre_q <= usr_preset;
          st_q  <= S_LOAD;
        end
        S_LOAD: begin
          cnt_q <= 2'(STEP_WAIT);
          st_q  <= S_WAIT;
        end
        S_WAIT: if (cnt_q == '0) st_q <= S_PRESET;
                else cnt_q <= cnt_q - 2'd1;
        S_PRESET: st_q <= S_IDLE;
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // Control request level
  always_ff @(posedge sys_clk) begin
    if (rst) req_q <= 1'b0;
    else     req_q <= usr_req;
  end

  assign link.cfg_byte      = cfg_q;
  assign link.units_per_rev = upr_q;
  assign link.total_range   = rng_q;
  assign link.cfg_load      = (st_q == S_LOAD);
  assign link.preset_req    = (st_q == S_PRESET);
  assign link.preset_val    = pre_q;
  assign link.plc_control_request_bit = req_q;
  assign link.enc_fault     = 1'b0;
  assign usr_busy           = (st_q != S_IDLE);
endmodule : epp_host

// file: tb/epp_chk.sv
`timescale 1ns/100ps
module epp_chk import epp_pkg::*; (
  // Clock and reset
  input wire logic          sys_clk,
  input wire logic          rst,
  // Link signals
  input wire logic          cfg_load,
  input wire logic [7:0]    cfg_byte,
  input wire logic [PW-1:0] units_per_rev,
  input wire logic [PW-1:0] total_range,
  input wire logic          preset_req,
  input wire logic          plc_control_request_bit,
  input wire logic          control_requested_status_bit,
  input wire logic          ctrl_valid,
  input wire logic [7:0]    profile_number_param,
  input wire logic [7:0]    life_fail_limit,
  input wire logic          cfg_bad
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // Scaling values inside the hardware bounds
  wire logic scale_ok = units_per_rev != 0 && units_per_rev <= HW_CPR
                        && total_range >= 2 && total_range <= HW_RANGE;
  // Quiet cycles between load and preset
  sequence s_gap;
    !preset_req [*4];
  endsequence
  load_preset_a: assert property (
    cfg_load |=> s_gap ##1 preset_req) else $error("no preset after load");
  prof_num_a: assert property (
    cfg_load |=> ##1 profile_number_param ==
      ($past(cfg_byte[BIT_COMPAT], 2) ? PROF_NEW : PROF_COMPAT))
    else $error("profile number wrong");
  compat_ctrl_a: assert property (
    profile_number_param == PROF_COMPAT && $stable(profile_number_param)
    |-> ctrl_valid && !control_requested_status_bit)
    else $error("compat control bits wrong");
  req_follow_a: assert property (
    profile_number_param == PROF_NEW && $stable(profile_number_param) &&
    $past(profile_number_param, 2) == PROF_NEW && !$past(rst)
    |-> ctrl_valid == $past(plc_control_request_bit))
    else $error("valid does not follow request");
  life_lim_a: assert property (
    profile_number_param == PROF_NEW |-> life_fail_limit == LIFE_DEFAULT)
    else $error("life limit wrong");
  scale_bad_a: assert property (
    cfg_load && !scale_ok |=> cfg_bad) else $error("bad scaling accepted");
  scale_good_a: assert property (
    cfg_load && scale_ok |=> !cfg_bad) else $error("good scaling refused");
  load_pulse_a: assert property (
    cfg_load |=> !cfg_load) else $error("load not a pulse");
endmodule : epp_chk

// file: tb/encoder_position_parameter_logic_tb.sv
`timescale 1ns/100ps
`define CHK(n,e,s) begin num_checks++; if ((s) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module encoder_position_parameter_logic_tb;
  import epp_pkg::*;
  logic          sys_clk = 0;
  logic          rst = 1;
  logic          usr_load = 0;
  logic          usr_req = 0;
  logic          raw_fault = 0;
  logic          usr_busy;
  logic [7:0]    usr_cfg = 8'h22;
  logic [PW-1:0] usr_upr = HW_CPR;
  logic [PW-1:0] usr_rng = HW_RANGE;
  logic [PW-1:0] usr_preset = 32'h0;
  logic [PW-1:0] raw_pos = 32'h0002_8000;
  logic [PW-1:0] bu [4] = '{32'h0, 32'h1_0001, 32'h100, 32'h100};
  logic [PW-1:0] br [4] = '{32'h1000, 32'h1000, 32'h1, 32'h4000_0001};
  // Host clamps units and upper range, so only a short range is refused
  logic          be [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
  int            num_errors = 0;
  int            num_checks = 0;
  epp_link_if link ();
  // Clock
  always #5 sys_clk = ~sys_clk;
  epp_device i_epp_device (.sys_clk(sys_clk), .rst(rst), .link(link),
    .raw_pos(raw_pos), .raw_fault(raw_fault));
  epp_host i_epp_host (.sys_clk(sys_clk), .rst(rst), .link(link),
    .usr_load(usr_load), .usr_cfg(usr_cfg), .usr_upr(usr_upr),
    .usr_rng(usr_rng), .usr_preset(usr_preset), .usr_req(usr_req),
    .usr_busy(usr_busy));
  epp_chk i_epp_chk (.sys_clk(sys_clk), .rst(rst),
    .cfg_load(link.cfg_load), .cfg_byte(link.cfg_byte),
    .units_per_rev(link.units_per_rev), .total_range(link.total_range),
    .preset_req(link.preset_req),
    .plc_control_request_bit(link.plc_control_request_bit),
    .control_requested_status_bit(link.control_requested_status_bit),
    .ctrl_valid(link.ctrl_valid),
    .profile_number_param(link.profile_number_param),
    .life_fail_limit(link.life_fail_limit), .cfg_bad(link.cfg_bad));
  task tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick
  // Load settings, then wait for the host preset to finish
  task run(input logic [7:0] c, input logic [PW-1:0] u, r, p);
    int i;
    usr_cfg = c;
    usr_upr = u;
    usr_rng = r;
    usr_preset = p;
    usr_load = 1;
    tick(1);
    usr_load = 0;
    tick(2);
    for (i = 0; i < 50 && usr_busy !== 1'b0; i++) tick(1);
    tick(5);
  endtask : run
  task conclude;
    if (num_errors == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : conclude
  // Watchdog
  initial begin
    #50us;
    num_errors++;
    conclude;
  end
  // Main sequence
  initial begin
    tick(16);
    rst = 0;
    tick(1);
    `CHK("profile", PROF_NEW, link.profile_number_param)
    `CHK("life", LIFE_DEFAULT, link.life_fail_limit)
    run(8'h2e, 32'h100, 32'h1000, 32'h5);
    `CHK("w1", 32'h280, link.position_word_one)
    `CHK("w2", 32'h5, link.position_word_two)
    `CHK("w3", 32'h5, link.position_word_three)
    `CHK("valid", 1'b0, link.ctrl_valid)
    run(8'h2f, 32'h100, 32'h1000, 32'h5);
    `CHK("w1 ccw", 32'hd80, link.position_word_one)
    run(8'h2e, 32'h100, 32'h200, 32'h5);
    `CHK("w1 wrap", 32'h80, link.position_word_one)
    run(8'h26, HW_CPR, HW_RANGE, 32'h5);
    `CHK("w1 hw", 32'h2_8000, link.position_word_one)
    run(8'h2a, 32'h100, 32'h1000, 32'h7);
    `CHK("w1 pre", 32'h7, link.position_word_one)
    // Class function off: all three settings ignored
    run(8'h2d, 32'h100, 32'h1000, 32'h5);
    raw_pos = 32'h0002_8100;
    tick(5);
    `CHK("w1 raw", 32'h105, link.position_word_one)
    `CHK("w2 raw", 32'h105, link.position_word_two)
    `CHK("w3 raw", 32'h105, link.position_word_three)
    raw_pos = 32'h0002_8000;
    for (int k = 0; k < 4; k++) begin
      run(8'h2e, bu[k], br[k], 32'h5);
      `CHK("bad", be[k], link.cfg_bad)
    end
    run(8'h2e, HW_CPR, HW_RANGE, 32'h5);
    `CHK("good", 1'b0, link.cfg_bad)
    // Compatibility mode and alarm channel
    run(8'h0e, 32'h100, 32'h1000, 32'h5);
    `CHK("profile c", PROF_COMPAT, link.profile_number_param)
    `CHK("valid c", 1'b1, link.ctrl_valid)
    `CHK("status c", 1'b0, link.control_requested_status_bit)
    raw_fault = 1;
    tick(5);
    `CHK("alarm off", 1'b0, link.alarm_diag)
    run(8'h1e, 32'h100, 32'h1000, 32'h5);
    `CHK("alarm on", 1'b1, link.alarm_diag)
    run(8'h2e, 32'h100, 32'h1000, 32'h5);
    `CHK("alarm new", 1'b1, link.alarm_diag)
    usr_req = 1;
    raw_fault = 0;
    tick(5);
    `CHK("alarm clr", 1'b0, link.alarm_diag)
    `CHK("valid req", 1'b1, link.ctrl_valid)
    conclude;
  end
endmodule : encoder_position_parameter_logic_tb
